// >>> verilog/tef_txq_pkg.sv
// constants for the transmit event fifo and transmit queue register block
package tef_txq_pkg;
  // register indices on the register port
  localparam logic [3:0] IDX_EVENT_CTRL = 4'h0;
  localparam logic [3:0] IDX_EVENT_STAT = 4'h1;
  localparam logic [3:0] IDX_EVENT_ADDR = 4'h2;
  localparam logic [3:0] IDX_TXQ_CTRL = 4'h3;
  // field positions
  localparam int BIT_PAYLOAD_SIZE_FIELD_LO = 29;
  localparam int BIT_DEPTH_FIELD_LO = 24;
  localparam int BIT_RETRY_LO = 21;
  localparam int BIT_PRI_LO = 16;
  localparam int BIT_FIFO_RESET_BIT = 10;
  localparam int BIT_SEND_REQUEST_BIT = 9;
  localparam int BIT_POINTER_INCREMENT_BIT = 8;
  localparam int BIT_DIRECTION_IS_TRANSMIT = 7;
  localparam int BIT_TSEN = 5;
  localparam int BIT_ATIE = 4;
  localparam int BIT_OVF = 3;
  localparam int BIT_FULL = 2;
  localparam int BIT_HALF = 1;
  localparam int BIT_NE = 0;
  localparam int BIT_QEIE = 2;
  localparam int BIT_QNIE = 0;
  // reset values
  localparam logic [4:0] RST_DEPTH_FIELD = 5'h00;
  localparam logic [2:0] RST_PAYLOAD_SIZE_FIELD = 3'h0;
  localparam logic [1:0] RST_RETRY = 2'h3;
  localparam logic [4:0] RST_PRI = 5'h00;
  localparam logic RST_FIFO_RESET_BIT = 1'b1;
  // retry policy codes
  localparam logic [1:0] RETRY_NONE = 2'h0;
  localparam logic [1:0] RETRY_THREE = 2'h1;
  localparam logic [1:0] RETRY_UNLIM = 2'h2;
  // event object layout in message ram
  localparam logic [31:0] EVENT_RAM_BASE = 32'h0000_0400;
  localparam logic [31:0] OBJ_BYTES_PLAIN = 32'h0000_0008;
  localparam logic [31:0] OBJ_BYTES_STAMP = 32'h0000_000c;
  localparam int STAGE_DEPTH = 16;
  localparam int STAGE_AW = 4;
  localparam int EVT_W = 64;
endpackage : tef_txq_pkg

// >>> verilog/tef_txq_regs.sv
// transmit event fifo and transmit queue control, status and pointer logic
//
// Behaviour
// - depth field value plus one gives messages held, zero is one, all ones 32
// - writing one to event fifo reset resets it, bit self-clears, zero ignored
// - event increment bit advances the tail by one object, reads back zero
// - time stamp enable attaches a stamp to each stored event object
// - depth, stamp enable and payload size change only in configuration mode
// - event control holds overflow, full, half and not-empty interrupt enables
// - overflow flag is set by hardware and held until software clears it
// - full, half and not-empty are live read-only status of occupancy
// - event read address returns ram address of the current tail object
// - retry field 00 none, 01 three, 10 or 11 unlimited, resets to 11
// - queue retry limit applies only while the global limit enable is set
// - queue priority five bits, zero lowest and all ones highest
// - queue reset bit held one in configuration mode, cleared in normal mode
// - send request updated on message completion, abort and queue reset
// - software sets send request, device clears when sent, clearing aborts
// - queue increment bit advances the queue head by one message
// - queue direction bit is read-only and always reads one
// - queue control holds attempts exhausted, empty and not-full enables
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// staging fifo between event source and message ram writer
module event_stage_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // handshakes and next occupancy
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  // occupancy and registered full/empty
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  // storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : event_stage_fifo

////////////////////////////////////////////////////////////////////////////////
// register block top
module tef_txq_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic config_mode,
  input wire logic global_retry_limit_enable,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic evt_valid,
  output logic evt_ready,
  input wire logic [31:0] evt_data,
  input wire logic [31:0] evt_stamp,
  output logic ram_wr_valid,
  input wire logic ram_wr_ready,
  output logic [31:0] ram_wr_addr,
  output logic [tef_txq_pkg::EVT_W-1:0] ram_wr_data,
  output logic ram_wr_stamped,
  input wire logic txq_msg_done,
  input wire logic txq_msg_abort,
  input wire logic txq_attempts_exhausted,
  input wire logic txq_empty,
  input wire logic txq_not_full,
  output logic event_irq,
  output logic txq_irq,
  output logic txq_send_request,
  output logic txq_abort_request,
  output logic txq_in_reset,
  output logic [4:0] txq_head,
  output logic [4:0] txq_depth_code,
  output logic [6:0] txq_payload_bytes,
  output logic [4:0] txq_priority,
  output logic [1:0] txq_retry_policy
);
  import tef_txq_pkg::*;

  logic [4:0] ev_depth_field;
  logic ev_tsen;
  logic [3:0] ev_ie;
  logic ev_fifo_reset_bit;
  logic ev_ovf;
  logic [4:0] ev_head;
  logic [4:0] ev_tail;
  logic [5:0] ev_count;
  logic [5:0] ev_depth;
  logic ev_full;
  logic ev_half;
  logic ev_ne;
  logic [2:0] q_payload_size_field;
  logic [1:0] q_retry;
  logic [2:0] q_ie;
  logic wr_ev_ctrl;
  logic wr_ev_stat;
  logic wr_q_ctrl;
  logic stage_valid;
  logic [EVT_W-1:0] stage_data;
  logic stage_ready;
  logic pop_obj;
  logic store;
  logic overflow_evt;
  logic tail_step;
  logic q_sw_clear;
  logic [31:0] obj_bytes;
  logic [31:0] ev_tail_addr;
  logic [31:0] rd_word;

  // next index with wrap at the programmed depth
  function automatic logic [4:0] next_index(input logic [4:0] idx, input logic [4:0] fsz);
    next_index = (idx == fsz) ? 5'h00 : idx + 5'h01;
  endfunction : next_index

  // payload byte count per size code
  function automatic logic [6:0] payload_bytes(input logic [2:0] code);
    case (code)
      3'h0: payload_bytes = 7'h08;
      3'h1: payload_bytes = 7'h0c;
      3'h2: payload_bytes = 7'h10;
      3'h3: payload_bytes = 7'h14;
      3'h4: payload_bytes = 7'h18;
      3'h5: payload_bytes = 7'h20;
      3'h6: payload_bytes = 7'h30;
      default: payload_bytes = 7'h40;
    endcase
  endfunction : payload_bytes

  //////////////////////////////////////////////////////////////////////////////
  // decode and live status
  assign wr_ev_ctrl = reg_wr && reg_addr == IDX_EVENT_CTRL;
  assign wr_ev_stat = reg_wr && reg_addr == IDX_EVENT_STAT;
  assign wr_q_ctrl = reg_wr && reg_addr == IDX_TXQ_CTRL;
  assign ev_depth = {1'b0, ev_depth_field} + 6'h01;
  assign ev_full = ev_count == ev_depth;
  assign ev_half = {ev_count, 1'b0} >= {1'b0, ev_depth};
  assign ev_ne = ev_count != 6'h00;
  assign obj_bytes = ev_tsen ? OBJ_BYTES_STAMP : OBJ_BYTES_PLAIN;
  assign ev_tail_addr = EVENT_RAM_BASE + 32'(ev_tail) * obj_bytes;

  // drain the staging fifo into message ram; stalls on ram back-pressure
  assign stage_ready = (!ram_wr_valid || ram_wr_ready) && !ev_fifo_reset_bit;
  assign pop_obj = stage_valid && stage_ready;
  assign store = pop_obj && !ev_full;
  assign overflow_evt = pop_obj && ev_full;
  assign tail_step = wr_ev_ctrl && reg_wdata[BIT_POINTER_INCREMENT_BIT] && ev_ne && !ev_fifo_reset_bit;
  assign q_sw_clear = wr_q_ctrl && !reg_wdata[BIT_SEND_REQUEST_BIT] && txq_send_request;

  event_stage_fifo #(
    .WIDTH(EVT_W),
    .DEPTH(STAGE_DEPTH),
    .AW(STAGE_AW)
  ) u_stage (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(evt_valid),
    .in_ready(evt_ready),
    .in_data({evt_stamp, evt_data}),
    .out_valid(stage_valid),
    .out_ready(stage_ready),
    .out_data(stage_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // event fifo configuration, depth and stamp enable gated by mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ev_depth_field <= RST_DEPTH_FIELD;
      ev_tsen <= 1'b0;
      ev_ie <= 4'h0;
    end else if (wr_ev_ctrl) begin
      if (config_mode) begin
        ev_depth_field <= reg_wdata[BIT_DEPTH_FIELD_LO +: 5];
        ev_tsen <= reg_wdata[BIT_TSEN];
      end
      ev_ie <= reg_wdata[3:0];
    end
  end

  // event fifo reset request, cleared once the reset cycle has run
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ev_fifo_reset_bit <= RST_FIFO_RESET_BIT;
    end else if (wr_ev_ctrl && reg_wdata[BIT_FIFO_RESET_BIT]) begin
      ev_fifo_reset_bit <= 1'b1;
    end else if (ev_fifo_reset_bit) begin
      ev_fifo_reset_bit <= 1'b0;
    end
  end

  // event fifo head, tail and occupancy
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ev_head <= 5'h00;
      ev_tail <= 5'h00;
      ev_count <= 6'h00;
    end else if (ev_fifo_reset_bit) begin
      ev_head <= 5'h00;
      ev_tail <= 5'h00;
      ev_count <= 6'h00;
    end else begin
      if (store) begin
        ev_head <= next_index(ev_head, ev_depth_field);
      end
      if (tail_step) begin
        ev_tail <= next_index(ev_tail, ev_depth_field);
      end
      if (store && !tail_step) begin
        ev_count <= ev_count + 6'h01;
      end else if (tail_step && !store) begin
        ev_count <= ev_count - 6'h01;
      end
    end
  end

  // overflow flag: hardware set wins over a software clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ev_ovf <= 1'b0;
    end else if (overflow_evt) begin
      ev_ovf <= 1'b1;
    end else if (wr_ev_stat && !reg_wdata[BIT_OVF]) begin
      ev_ovf <= 1'b0;
    end
  end

  // message ram write port
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ram_wr_valid <= 1'b0;
      ram_wr_addr <= 32'h0000_0000;
      ram_wr_data <= '0;
      ram_wr_stamped <= 1'b0;
    end else if (store) begin
      ram_wr_valid <= 1'b1;
      ram_wr_addr <= EVENT_RAM_BASE + 32'(ev_head) * obj_bytes;
      ram_wr_data <= ev_tsen ? stage_data : {32'h0000_0000, stage_data[31:0]};
      ram_wr_stamped <= ev_tsen;
    end else if (ram_wr_ready) begin
      ram_wr_valid <= 1'b0;
    end
  end

  // event interrupt, each condition gated by its enable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |({ev_ovf, ev_full, ev_half, ev_ne} & ev_ie);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit queue configuration
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_payload_size_field <= RST_PAYLOAD_SIZE_FIELD;
      txq_depth_code <= RST_DEPTH_FIELD;
      q_retry <= RST_RETRY;
      txq_priority <= RST_PRI;
      q_ie <= 3'h0;
    end else if (wr_q_ctrl) begin
      if (config_mode) begin
        q_payload_size_field <= reg_wdata[BIT_PAYLOAD_SIZE_FIELD_LO +: 3];
        txq_depth_code <= reg_wdata[BIT_DEPTH_FIELD_LO +: 5];
      end
      q_retry <= reg_wdata[BIT_RETRY_LO +: 2];
      txq_priority <= reg_wdata[BIT_PRI_LO +: 5];
      q_ie <= {reg_wdata[BIT_ATIE], reg_wdata[BIT_QEIE], reg_wdata[BIT_QNIE]};
    end
  end

  // queue reset held in configuration mode, released in normal mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txq_in_reset <= RST_FIFO_RESET_BIT;
    end else begin
      txq_in_reset <= config_mode || (wr_q_ctrl && reg_wdata[BIT_FIFO_RESET_BIT]);
    end
  end

  // queue head pointer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txq_head <= 5'h00;
    end else if (txq_in_reset) begin
      txq_head <= 5'h00;
    end else if (wr_q_ctrl && reg_wdata[BIT_POINTER_INCREMENT_BIT]) begin
      txq_head <= next_index(txq_head, txq_depth_code);
    end
  end

  // send request: software set wins over hardware clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txq_send_request <= 1'b0;
      txq_abort_request <= 1'b0;
    end else begin
      txq_abort_request <= q_sw_clear;
      if (wr_q_ctrl && reg_wdata[BIT_SEND_REQUEST_BIT]) begin
        txq_send_request <= 1'b1;
      end else if (txq_in_reset || txq_msg_done || txq_msg_abort || q_sw_clear) begin
        txq_send_request <= 1'b0;
      end
    end
  end

  // decoded queue settings and interrupt
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txq_payload_bytes <= 7'h08;
      txq_retry_policy <= RETRY_UNLIM;
      txq_irq <= 1'b0;
    end else begin
      txq_payload_bytes <= payload_bytes(q_payload_size_field);
      if (!global_retry_limit_enable || q_retry[1]) begin
        txq_retry_policy <= RETRY_UNLIM;
      end else begin
        txq_retry_policy <= q_retry[0] ? RETRY_THREE : RETRY_NONE;
      end
      txq_irq <= |(q_ie & {txq_attempts_exhausted, txq_empty, txq_not_full});
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read word assembly; unmapped indices read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_addr)
      IDX_EVENT_CTRL: begin
        rd_word[BIT_DEPTH_FIELD_LO +: 5] = ev_depth_field;
        rd_word[BIT_FIFO_RESET_BIT] = ev_fifo_reset_bit;
        rd_word[BIT_TSEN] = ev_tsen;
        rd_word[3:0] = ev_ie;
      end
      IDX_EVENT_STAT: begin
        rd_word[BIT_OVF] = ev_ovf;
        rd_word[BIT_FULL] = ev_full;
        rd_word[BIT_HALF] = ev_half;
        rd_word[BIT_NE] = ev_ne;
      end
      IDX_EVENT_ADDR: rd_word = ev_tail_addr;
      IDX_TXQ_CTRL: begin
        rd_word[BIT_PAYLOAD_SIZE_FIELD_LO +: 3] = q_payload_size_field;
        rd_word[BIT_DEPTH_FIELD_LO +: 5] = txq_depth_code;
        rd_word[BIT_RETRY_LO +: 2] = q_retry;
        rd_word[BIT_PRI_LO +: 5] = txq_priority;
        rd_word[BIT_FIFO_RESET_BIT] = txq_in_reset;
        rd_word[BIT_SEND_REQUEST_BIT] = txq_send_request;
        rd_word[BIT_DIRECTION_IS_TRANSMIT] = 1'b1;
        rd_word[BIT_ATIE] = q_ie[2];
        rd_word[BIT_QEIE] = q_ie[1];
        rd_word[BIT_QNIE] = q_ie[0];
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // registered read data
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_word;
    end
  end
endmodule : tef_txq_regs

`default_nettype wire

// >>> sim/ram_sink_model.sv
// message ram writer model that takes stored event objects with periodic stalls
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////
module ram_sink_model #(
  parameter int STALL = 2
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ram_wr_valid,
  output logic ram_wr_ready,
  input wire logic [31:0] ram_wr_addr,
  output logic [7:0] n_writes,
  output logic [31:0] last_addr
);
  logic [3:0] gap;

  // ready once every STALL+1 cycles, so objects wait at the store port
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gap <= 4'h0;
      ram_wr_ready <= 1'b0;
    end else begin
      gap <= (gap == 4'(STALL)) ? 4'h0 : gap + 4'h1;
      ram_wr_ready <= (gap == 4'(STALL));
    end
  end

  // count accepted objects and remember where the last one went
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      n_writes <= 8'h00;
      last_addr <= 32'h0;
    end else if (ram_wr_valid && ram_wr_ready) begin
      n_writes <= n_writes + 8'h01;
      last_addr <= ram_wr_addr;
    end
  end
endmodule : ram_sink_model
`default_nettype wire

// >>> sim/event_queue_asserts.sv
// assertions on the queue control and event store outputs
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////
module regs_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic config_mode,
  input wire logic global_retry_limit_enable,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic ram_wr_valid,
  input wire logic ram_wr_ready,
  input wire logic [31:0] ram_wr_addr,
  input wire logic [tef_txq_pkg::EVT_W-1:0] ram_wr_data,
  input wire logic ram_wr_stamped,
  input wire logic txq_msg_done,
  input wire logic txq_send_request,
  input wire logic txq_abort_request,
  input wire logic txq_in_reset,
  input wire logic [4:0] txq_depth_code,
  input wire logic [6:0] txq_payload_bytes,
  input wire logic [4:0] txq_priority,
  input wire logic [1:0] txq_retry_policy
);
  import tef_txq_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // queue control write, and a normal-mode cycle without a queue reset write
  sequence s_q_wr;
    reg_wr && reg_addr == IDX_TXQ_CTRL;
  endsequence
  sequence s_quiet_normal;
    !config_mode && !(reg_wr && reg_addr == IDX_TXQ_CTRL && reg_wdata[BIT_FIFO_RESET_BIT]);
  endsequence

  property p_req_set;
    s_q_wr ##0 reg_wdata[BIT_SEND_REQUEST_BIT] |=> txq_send_request;
  endproperty
  a_req_set: assert property (p_req_set) else $error("send request not set");
  property p_abort;
    s_q_wr ##0 (!reg_wdata[BIT_SEND_REQUEST_BIT] && txq_send_request)
      |=> (txq_abort_request && !txq_send_request) ##1 !txq_abort_request;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  property p_done;
    txq_msg_done && !(reg_wr && reg_addr == IDX_TXQ_CTRL && reg_wdata[BIT_SEND_REQUEST_BIT])
      |=> !txq_send_request;
  endproperty
  a_done: assert property (p_done) else $error("request kept after done");
  property p_cfg_reset;
    config_mode |=> txq_in_reset;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("queue reset low in config");
  property p_leave_reset;
    s_quiet_normal [*2] |=> !txq_in_reset;
  endproperty
  a_leave_reset: assert property (p_leave_reset) else $error("queue reset stuck");
  property p_retry_free;
    !global_retry_limit_enable |=> txq_retry_policy == RETRY_UNLIM;
  endproperty
  a_retry_free: assert property (p_retry_free) else $error("retry limited");
  property p_pri;
    s_q_wr |=> txq_priority == $past(reg_wdata[20:16]);
  endproperty
  a_pri: assert property (p_pri) else $error("priority not written");
  property p_size_lock;
    s_q_wr ##0 !config_mode |=> $stable(txq_depth_code) && $stable(txq_payload_bytes);
  endproperty
  a_size_lock: assert property (p_size_lock) else $error("size changed in normal");
  property p_hold;
    ram_wr_valid && !ram_wr_ready
      |=> ram_wr_valid && $stable(ram_wr_addr) && $stable(ram_wr_data);
  endproperty
  a_hold: assert property (p_hold) else $error("store object dropped");
  property p_no_stamp;
    ram_wr_valid && !ram_wr_stamped |-> ram_wr_data[63:32] == 32'h0;
  endproperty
  a_no_stamp: assert property (p_no_stamp) else $error("stamp on plain object");
endmodule : regs_checker

bind tef_txq_regs regs_checker chk (.mclk, .resetn, .config_mode,
  .global_retry_limit_enable, .reg_wr, .reg_addr, .reg_wdata, .ram_wr_valid,
  .ram_wr_ready, .ram_wr_addr, .ram_wr_data, .ram_wr_stamped, .txq_msg_done,
  .txq_send_request, .txq_abort_request, .txq_in_reset, .txq_depth_code,
  .txq_payload_bytes, .txq_priority, .txq_retry_policy);
`default_nettype wire

// >>> sim/tb_tx_event_fifo_and_tx_queue_ctrl.sv
// testbench for the event fifo and queue control register block
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////
module tb_tx_event_fifo_and_tx_queue_ctrl;
  import tef_txq_pkg::*;
  logic mclk, resetn, config_mode, global_retry_limit_enable, reg_wr, reg_rd;
  logic evt_valid, evt_ready, ram_wr_valid, ram_wr_ready, ram_wr_stamped, event_irq;
  logic txq_msg_done, txq_msg_abort, txq_attempts_exhausted, txq_empty, txq_not_full;
  logic txq_irq, txq_send_request, txq_abort_request, txq_in_reset;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, evt_data, evt_stamp, ram_wr_addr, v, last_addr;
  logic [63:0] ram_wr_data;
  logic [4:0] txq_head, txq_depth_code, txq_priority;
  logic [6:0] txq_payload_bytes;
  logic [1:0] txq_retry_policy;
  logic [7:0] n_writes;
  logic [6:0] pl_bytes [8] = '{7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
  int n_mismatch, compares, i;

  tef_txq_regs uut (.mclk, .resetn, .config_mode, .global_retry_limit_enable, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .evt_valid, .evt_ready, .evt_data,
    .evt_stamp, .ram_wr_valid, .ram_wr_ready, .ram_wr_addr, .ram_wr_data, .ram_wr_stamped,
    .txq_msg_done, .txq_msg_abort, .txq_attempts_exhausted, .txq_empty, .txq_not_full,
    .event_irq, .txq_irq, .txq_send_request, .txq_abort_request, .txq_in_reset, .txq_head,
    .txq_depth_code, .txq_payload_bytes, .txq_priority, .txq_retry_policy);
  ram_sink_model #(.STALL(2)) ram (.mclk, .resetn, .ram_wr_valid, .ram_wr_ready,
    .ram_wr_addr, .n_writes, .last_addr);

  // 125 MHz clock
  always #4 mclk = ~mclk;

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    check(v, e);
  endtask : rchk
  // host keeps reading until the masked bits settle
  task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    int k;
    rd(a);
    for (k = 0; k < 60 && (v & m) !== e; k++) rd(a);
    check(v & m, e);
  endtask : poll
  task automatic push(input logic [31:0] d);
    @(negedge mclk);
    evt_valid = 1'b1;
    evt_data = d;
    evt_stamp = d + 32'h100;
    while (!evt_ready) @(negedge mclk);
    @(negedge mclk);
    evt_valid = 1'b0;
  endtask : push
  task automatic wait_writes(input logic [7:0] n);
    int k;
    for (k = 0; k < 200 && n_writes !== n; k++) @(negedge mclk);
    check({24'h0, n_writes}, {24'h0, n});
  endtask : wait_writes
  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    finish_test;
  end

  // main sequence
  initial begin
    {mclk, resetn, reg_wr, reg_rd, evt_valid, txq_msg_done, txq_msg_abort} = 7'h00;
    {txq_attempts_exhausted, txq_empty} = 2'h0;
    {config_mode, global_retry_limit_enable, txq_not_full} = 3'h7;
    {reg_addr, reg_wdata, evt_data, evt_stamp} = 100'h0;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    rchk(IDX_EVENT_CTRL, 32'h0);
    rchk(IDX_EVENT_STAT, 32'h0);
    rchk(IDX_TXQ_CTRL, 32'h0060_0480);
    rchk(4'h7, 32'h0);
    // one plain object fills a one-deep store, the next one overflows
    push(32'h1111_0000);
    wait_writes(8'h01);
    check(last_addr, EVENT_RAM_BASE);
    rchk(IDX_EVENT_STAT, 32'h7);
    push(32'h2222_0000);
    poll(IDX_EVENT_STAT, 32'hf, 32'hf);
    wr(IDX_EVENT_CTRL, 32'h0000_0400);
    poll(IDX_EVENT_CTRL, 32'h400, 32'h0);
    rchk(IDX_EVENT_STAT, 32'h8);
    // four deep, stamped, all enables; every payload and retry code
    wr(IDX_EVENT_CTRL, 32'h0300_002f);
    rchk(IDX_EVENT_CTRL, 32'h0300_002f);
    for (i = 0; i < 8; i++) begin
      wr(IDX_TXQ_CTRL, {i[2:0], 5'h03, 1'b0, i[1:0], 5'h1f, 16'h0});
      // decoded settings are registered one cycle after the field
      @(negedge mclk);
      check({25'h0, txq_payload_bytes}, {25'h0, pl_bytes[i]});
      check({30'h0, txq_retry_policy}, (i[1:0] == 2'h3) ? 32'h2 : {30'h0, i[1:0]});
    end
    check({27'h0, txq_depth_code}, 32'h3);
    check({27'h0, txq_priority}, 32'h1f);
    // three retries while the global limit is on, unlimited once it is off
    wr(IDX_TXQ_CTRL, 32'he33f_0000);
    @(negedge mclk);
    check({30'h0, txq_retry_policy}, {30'h0, RETRY_THREE});
    global_retry_limit_enable = 1'b0;
    @(negedge mclk);
    check({30'h0, txq_retry_policy}, 32'h2);
    // normal mode: configuration fields locked
    config_mode = 1'b0;
    repeat (3) @(negedge mclk);
    check({31'h0, txq_in_reset}, 32'h0);
    wr(IDX_EVENT_CTRL, 32'h0000_000f);
    rchk(IDX_EVENT_CTRL, 32'h0300_002f);
    rchk(IDX_TXQ_CTRL, 32'he33f_0080);
    for (i = 0; i < 5; i++) push(32'h3000_0000 + i);
    wait_writes(8'h05);
    check(last_addr, EVENT_RAM_BASE + 3 * OBJ_BYTES_STAMP);
    poll(IDX_EVENT_STAT, 32'hf, 32'hf);
    check({31'h0, event_irq}, 32'h1);
    rchk(IDX_EVENT_ADDR, EVENT_RAM_BASE);
    wr(IDX_EVENT_CTRL, 32'h0300_012f);
    rchk(IDX_EVENT_ADDR, EVENT_RAM_BASE + OBJ_BYTES_STAMP);
    rchk(IDX_EVENT_STAT, 32'hb);
    wr(IDX_EVENT_STAT, 32'h0);
    rchk(IDX_EVENT_STAT, 32'h3);
    wr(IDX_EVENT_CTRL, 32'h0300_0020);
    @(negedge mclk);
    check({31'h0, event_irq}, 32'h0);
    // queue request, completion, abort, head step and interrupt enables
    wr(IDX_TXQ_CTRL, 32'h003f_0200);
    check({31'h0, txq_send_request}, 32'h1);
    check({25'h0, txq_payload_bytes}, 32'h40);
    @(negedge mclk);
    txq_msg_done = 1'b1;
    @(negedge mclk);
    txq_msg_done = 1'b0;
    check({31'h0, txq_send_request}, 32'h0);
    wr(IDX_TXQ_CTRL, 32'h003f_0200);
    wr(IDX_TXQ_CTRL, 32'h003f_0000);
    check({31'h0, txq_abort_request}, 32'h1);
    check({31'h0, txq_send_request}, 32'h0);
    // a finished abort also drops the request
    wr(IDX_TXQ_CTRL, 32'h003f_0200);
    txq_msg_abort = 1'b1;
    @(negedge mclk);
    txq_msg_abort = 1'b0;
    check({31'h0, txq_abort_request}, 32'h0);
    check({31'h0, txq_send_request}, 32'h0);
    wr(IDX_TXQ_CTRL, 32'h003f_0100);
    check({27'h0, txq_head}, 32'h1);
    wr(IDX_TXQ_CTRL, 32'h003f_0001);
    @(negedge mclk);
    check({31'h0, txq_irq}, 32'h1);
    // not-full status gone, then the empty enable with the queue empty
    txq_not_full = 1'b0;
    @(negedge mclk);
    check({31'h0, txq_irq}, 32'h0);
    txq_empty = 1'b1;
    wr(IDX_TXQ_CTRL, 32'h003f_0004);
    @(negedge mclk);
    check({31'h0, txq_irq}, 32'h1);
    wr(IDX_TXQ_CTRL, 32'h003f_0000);
    @(negedge mclk);
    check({31'h0, txq_irq}, 32'h0);
    finish_test;
  end
endmodule : tb_tx_event_fifo_and_tx_queue_ctrl
`default_nettype wire
